// ===== estop_field_model.sv
// Field model of the external safety wiring on terminals 1 and 3.
// Assumes the bench changes its commands just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module estop_field_model (
  input  wire logic stop_cmd_in,
  input  wire logic open_cmd_in,
  input  wire logic press_cmd_in,
  output var  logic trip_reset_input_out,
  output var  logic emergency_stop_input_out
);
  // ==========================================================================
  // Contacts
  // Normally-open push button, the only way out of a trip
  always_comb begin
    trip_reset_input_out = press_cmd_in;
  end

  // Closed loop reads high; a pressed stop or a cut wire both read low
  always_comb begin
    emergency_stop_input_out = !(stop_cmd_in || open_cmd_in);
  end
endmodule // estop_field_model
`default_nettype wire

// ===== estop_interlock.sv
// Emergency-stop interlock: hardware trip path plus terminal function table upkeep.
// Assumes terminal levels are synchronous to ref_clk_in, high meaning contact closed.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - Feature acts only while the enable switch is on; off by default. A trip latched before switch-off stays latched.
// RULE2 - When enabled, terminals 1 and 3 are dedicated; other functions there disabled.
// RULE3 - Enabled terminal 1 is a normally-open reset that clears the trip.
// RULE4 - Enabled terminal 3 released halts switching in hardware and trips.
// RULE5 - Stop removes only power-stage switching, never the device's supply.
// RULE6 - Open or wrong-polarity terminal 3 counts as an emergency stop.
// RULE7 - Only a terminal 1 reset clears the trip; panel clears are ignored.
// RULE8 - Switch on sets terminal 3 to code 64 with polarity 01.
// RULE9 - Any terminal holding code 18 gets polarity forced to 00.
// RULE10 - Switch on clears code 18 elsewhere and places it on terminal 1.
// RULE11 - Switch off after on keeps terminal 1 code 18, terminal 3 none.
// RULE12 - Panel writes assigning code 64 to terminal 3 are refused.
// RULE13 - Copy into enabled unit skips terminals 1 and 3, shows brief error.
// RULE14 - Trip stays latched until terminal 1 reset, even if terminal 3 closes.
module estop_interlock
  import estop_pkg::*;
#(
  parameter int unsigned COPY_ERR_LEN = estop_pkg::COPY_ERR_CYCLES
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        estop_enable_switch_in,
  input  wire logic                        trip_reset_input_in,
  input  wire logic                        emergency_stop_input_in,
  input  wire logic                        wr_in,
  input  wire logic                        wr_copy_in,
  input  wire logic [estop_pkg::IDX_W-1:0]  wr_term_in,
  input  wire logic [estop_pkg::CODE_W-1:0] wr_func_in,
  input  wire logic [estop_pkg::POL_W-1:0]  wr_pol_in,
  input  wire logic [estop_pkg::IDX_W-1:0]  rd_term_in,
  output var  logic [estop_pkg::CODE_W-1:0] rd_func_out,
  output var  logic [estop_pkg::POL_W-1:0]  rd_pol_out,
  output var  logic                        gate_enable_out,
  output var  logic                        estop_trip_out,
  output var  logic [estop_pkg::CODE_W-1:0] trip_code_out,
  output var  logic                        device_reset_out,
  output var  logic                        wr_refused_out,
  output var  logic                        copy_error_out,
  output var  logic                        busy_out,
  output var  logic                        estop_assigned_out
);
  import estop_pkg::*;

  // ==========================================================================
  // Helpers

  // Terminals 1 and 3 are reserved while the feature is on
  function automatic logic is_dedicated(input logic [IDX_W-1:0] idx);
    return (idx == TERM1_IDX) || (idx == TERM3_IDX);
  endfunction

  // Polarity that a function code forces on its terminal
  function automatic logic [POL_W-1:0] fix_pol(input logic [CODE_W-1:0] func,
                                               input logic [POL_W-1:0]  pol);
    if (func == FUNC_TRIP_RESET) begin
      return POL_NO; // RULE9
    end else if (func == FUNC_ESTOP) begin
      return POL_NC;
    end
    return pol;
  endfunction

  // ==========================================================================
  // Table instance
  term_table_if tbl_bus ();

  term_table u_table (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .tbl        (tbl_bus.store)
  );

  // ==========================================================================
  // Hardware trip path: no table or software in the loop, so a table update
  // in flight can never delay a stop.
  logic                        trip;
  logic                        next_trip;
  logic                        reset_prev;
  logic                        reset_edge;
  logic                        stop_req;
  logic                        next_gate_enable;
  logic [CODE_W-1:0]           next_trip_code;
  logic                        next_device_reset;

  // Trip set and clear; the set wins when both arrive together
  always_comb begin
    reset_edge = estop_enable_switch_in && trip_reset_input_in && !reset_prev; // RULE3
    // A low level means released, open or miswired: all treated alike
    stop_req   = estop_enable_switch_in && !emergency_stop_input_in; // RULE1 RULE4 RULE6
    next_trip  = trip;
    if (stop_req) begin
      next_trip = 1'b1; // RULE4
    end else if (reset_edge) begin
      next_trip = 1'b0; // RULE7
    end
    // Only the gate drive is withdrawn; no supply control exists here
    next_gate_enable  = !next_trip; // RULE5
    next_trip_code    = next_trip ? ESTOP_TRIP_CODE : NO_TRIP_CODE;
    next_device_reset = reset_edge; // RULE3
  end

  // Trip registers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trip             <= 1'b0;
      reset_prev       <= 1'b0;
      gate_enable_out  <= 1'b0;
      estop_trip_out   <= 1'b0;
      trip_code_out    <= NO_TRIP_CODE;
      device_reset_out <= 1'b0;
    end else begin
      trip             <= next_trip; // RULE14
      reset_prev       <= trip_reset_input_in;
      gate_enable_out  <= next_gate_enable;
      estop_trip_out   <= next_trip;
      trip_code_out    <= next_trip_code;
      device_reset_out <= next_device_reset;
    end
  end

  // ==========================================================================
  // Table reassignment sequencer and external writes
  seq_state_type           state;
  seq_state_type           next_state;
  logic [IDX_W-1:0]        scan_idx;
  logic [IDX_W-1:0]        next_scan_idx;
  logic                    applied;
  logic                    next_applied;
  logic                    next_busy;
  logic                    next_refused;
  logic                    copy_start;
  logic                    ext_accept;
  logic                    ext_bad;
  logic [COPY_CNT_W-1:0]   copy_cnt;
  logic [COPY_CNT_W-1:0]   next_copy_cnt;

  // Next state, table port and write screening
  always_comb begin
    next_state    = state;
    next_scan_idx = scan_idx;
    next_applied  = applied;
    tbl_bus.we    = 1'b0;
    tbl_bus.waddr = wr_term_in;
    tbl_bus.wfunc = wr_func_in;
    tbl_bus.wpol  = fix_pol(wr_func_in, wr_pol_in);
    tbl_bus.raddr = (state == ST_IDLE) ? rd_term_in : scan_idx;
    copy_start    = 1'b0;
    ext_accept    = 1'b0;
    next_refused  = 1'b0;
    // Only the switch may place code 64 on terminal 3
    ext_bad = (wr_func_in == FUNC_ESTOP) && (wr_term_in == TERM3_IDX); // RULE12

    unique case (state)
      ST_IDLE: begin
        if (estop_enable_switch_in && !applied) begin
          next_state    = ST_SCAN_RD;
          next_scan_idx = TERM1_IDX;
          next_applied  = 1'b1;
        end else if (!estop_enable_switch_in && applied) begin
          next_state   = ST_CLR_T3;
          next_applied = 1'b0;
        end else if (wr_in) begin
          if (estop_enable_switch_in && is_dedicated(wr_term_in)) begin
            copy_start   = wr_copy_in; // RULE13
            next_refused = !wr_copy_in; // RULE2
          end else if (ext_bad) begin
            next_refused = 1'b1; // RULE12
          end else begin
            ext_accept = 1'b1;
          end
        end
      end
      ST_SCAN_RD: begin
        next_state = ST_SCAN_CK;
      end
      ST_SCAN_CK: begin
        // Reset function found elsewhere is dropped to avoid duplication
        if ((tbl_bus.rfunc == FUNC_TRIP_RESET) && (scan_idx != TERM1_IDX)) begin
          tbl_bus.we    = 1'b1; // RULE10
          tbl_bus.waddr = scan_idx;
          tbl_bus.wfunc = FUNC_NONE;
          tbl_bus.wpol  = tbl_bus.rpol;
        end
        if (scan_idx == LAST_IDX) begin
          next_state = ST_SET_T1;
        end else begin
          next_state    = ST_SCAN_RD;
          next_scan_idx = IDX_W'(scan_idx + 3'h1);
        end
      end
      ST_SET_T1: begin
        tbl_bus.we    = 1'b1; // RULE10
        tbl_bus.waddr = TERM1_IDX;
        tbl_bus.wfunc = FUNC_TRIP_RESET;
        tbl_bus.wpol  = fix_pol(FUNC_TRIP_RESET, POL_NC); // RULE9
        next_state    = ST_SET_T3;
      end
      ST_SET_T3: begin
        tbl_bus.we    = 1'b1; // RULE8
        tbl_bus.waddr = TERM3_IDX;
        tbl_bus.wfunc = FUNC_ESTOP;
        tbl_bus.wpol  = POL_NC;
        next_state    = ST_IDLE;
      end
      ST_CLR_T3: begin
        // Terminal 1 stays as assigned; terminal 3 polarity is kept
        tbl_bus.we    = 1'b1; // RULE11
        tbl_bus.waddr = TERM3_IDX;
        tbl_bus.wfunc = FUNC_NONE;
        tbl_bus.wpol  = POL_NC;
        next_state    = ST_IDLE;
      end
    endcase

    if (ext_accept) begin
      tbl_bus.we = 1'b1;
    end
    // Writes while the sequencer runs, or in the cycle it starts, are turned away
    if (((state != ST_IDLE) || (next_state != ST_IDLE)) && wr_in) begin
      next_refused = 1'b1;
    end
    next_busy = (next_state != ST_IDLE);
  end

  // Copy error indication, retriggered by each skipped copy entry
  always_comb begin
    if (copy_start) begin
      next_copy_cnt = COPY_CNT_W'(COPY_ERR_LEN); // RULE13
    end else if (copy_cnt != COPY_CNT_ZERO) begin
      next_copy_cnt = COPY_CNT_W'(copy_cnt - COPY_CNT_ONE);
    end else begin
      next_copy_cnt = COPY_CNT_ZERO;
    end
  end

  // Sequencer and indication registers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state              <= ST_IDLE;
      scan_idx           <= TERM1_IDX;
      applied            <= 1'b0;
      copy_cnt           <= COPY_CNT_ZERO;
      busy_out           <= 1'b0;
      wr_refused_out     <= 1'b0;
      copy_error_out     <= 1'b0;
      estop_assigned_out <= 1'b0;
    end else begin
      state              <= next_state;
      scan_idx           <= next_scan_idx;
      applied            <= next_applied;
      copy_cnt           <= next_copy_cnt;
      busy_out           <= next_busy;
      wr_refused_out     <= next_refused;
      copy_error_out     <= (next_copy_cnt != COPY_CNT_ZERO);
      estop_assigned_out <= next_applied;
    end
  end

  // Read data leave the table straight from its output register
  assign rd_func_out = tbl_bus.rfunc;
  assign rd_pol_out  = tbl_bus.rpol;

endmodule // estop_interlock
`default_nettype wire

// ===== estop_interlock_properties.sv
// Concurrent checks on the ports of the emergency-stop interlock.
// Assumes one clock domain; bound onto every estop_interlock instance.
`timescale 1ns/1ps
`default_nettype none
module estop_interlock_properties
  import estop_pkg::*;
#(
  parameter int unsigned COPY_ERR_LEN = 8
) (
  input wire logic                         ref_clk_in,
  input wire logic                         nrst_in,
  input wire logic                         estop_enable_switch_in,
  input wire logic                         trip_reset_input_in,
  input wire logic                         emergency_stop_input_in,
  input wire logic                         wr_in,
  input wire logic                         wr_copy_in,
  input wire logic [estop_pkg::IDX_W-1:0]  wr_term_in,
  input wire logic [estop_pkg::CODE_W-1:0] wr_func_in,
  input wire logic                         gate_enable_out,
  input wire logic                         estop_trip_out,
  input wire logic [estop_pkg::CODE_W-1:0] trip_code_out,
  input wire logic                         wr_refused_out,
  input wire logic                         copy_error_out,
  input wire logic                         busy_out,
  input wire logic                         estop_assigned_out
);
  // ==========================================================================
  // Run-length helpers
  // Counters replace long repetitions, which the tools would unroll
  logic [5:0]  busy_run;
  logic [5:0]  next_busy_run;
  logic [19:0] copy_run;
  logic [19:0] next_copy_run;
  always_comb begin
    next_busy_run = busy_out ? busy_run + 6'h01 : 6'h00;
    next_copy_run = copy_error_out ? copy_run + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_run <= 6'h00;
      copy_run <= 20'h00000;
    end else begin
      busy_run <= next_busy_run;
      copy_run <= next_copy_run;
    end
  end

  // ==========================================================================
  // Steps and properties
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence stop_seen;
    estop_enable_switch_in && !emergency_stop_input_in;
  endsequence
  sequence reset_edge;
    estop_enable_switch_in && trip_reset_input_in && !$past(trip_reset_input_in);
  endsequence
  sequence on_request;
    !busy_out && estop_enable_switch_in && !estop_assigned_out;
  endsequence
  sequence skip_write;
    wr_in && wr_copy_in && !busy_out && estop_assigned_out && estop_enable_switch_in
      && wr_term_in == TERM1_IDX;
  endsequence

  stop_trips_a: assert property (stop_seen |=> estop_trip_out && !gate_enable_out)
    else $error("stop did not trip");
  trip_latch_a: assert property (estop_trip_out && !trip_reset_input_in |=> estop_trip_out)
    else $error("trip dropped without reset");
  trip_clear_a: assert property (estop_trip_out && emergency_stop_input_in ##0 reset_edge
    |=> !estop_trip_out && gate_enable_out) else $error("reset did not clear trip");
  switch_off_a: assert property (!estop_enable_switch_in && !estop_trip_out
    |=> !estop_trip_out && gate_enable_out) else $error("trip while disabled");
  trip_code_a: assert property (trip_code_out == (estop_trip_out ? ESTOP_TRIP_CODE : NO_TRIP_CODE))
    else $error("wrong trip code");
  panel_refuse_a: assert property (wr_in && !wr_copy_in && estop_enable_switch_in
    && (wr_term_in == TERM1_IDX || wr_term_in == TERM3_IDX) |-> ##[1:2] wr_refused_out)
    else $error("dedicated terminal write taken");
  estop_code_a: assert property (wr_in && !wr_copy_in && wr_term_in == TERM3_IDX
    && wr_func_in == FUNC_ESTOP |-> ##[1:2] wr_refused_out) else $error("stop code write taken");
  copy_skip_a: assert property (skip_write |-> ##[1:2] copy_error_out)
    else $error("no copy error");
  copy_len_a: assert property ($fell(copy_error_out) |-> copy_run >= 20'(COPY_ERR_LEN))
    else $error("copy error too short");
  seq_start_a: assert property (on_request |=> busy_out && estop_assigned_out)
    else $error("switch-on sequence not started");
  seq_length_a: assert property ($fell(busy_out)
    |-> busy_run == (estop_assigned_out ? 6'h12 : 6'h01)) else $error("sequence length wrong");
endmodule // estop_interlock_properties
bind estop_interlock estop_interlock_properties #(.COPY_ERR_LEN(COPY_ERR_LEN)) u_props (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .estop_enable_switch_in(estop_enable_switch_in),
  .trip_reset_input_in(trip_reset_input_in), .emergency_stop_input_in(emergency_stop_input_in),
  .wr_in(wr_in), .wr_copy_in(wr_copy_in), .wr_term_in(wr_term_in), .wr_func_in(wr_func_in),
  .gate_enable_out(gate_enable_out), .estop_trip_out(estop_trip_out),
  .trip_code_out(trip_code_out), .wr_refused_out(wr_refused_out),
  .copy_error_out(copy_error_out), .busy_out(busy_out), .estop_assigned_out(estop_assigned_out)
);
`default_nettype wire

// ===== estop_pkg.sv
// Constants, codes and state encoding for the emergency-stop interlock.
// Assumes a single 200 MHz clock domain; all terminal inputs are already synchronous.
`default_nettype none
package estop_pkg;

  // ==========================================================================
  // Terminal table geometry
  localparam int unsigned TERM_COUNT = 8;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned POL_W      = 2;

  // Terminal 1 and terminal 3 positions (terminal n sits at index n-1)
  localparam logic [IDX_W-1:0] TERM1_IDX = 3'h0;
  localparam logic [IDX_W-1:0] TERM3_IDX = 3'h2;
  localparam logic [IDX_W-1:0] LAST_IDX  = 3'h7;

  // ==========================================================================
  // Function and polarity codes
  localparam logic [CODE_W-1:0] FUNC_TRIP_RESET = 8'h12;  // Code 18, trip reset
  localparam logic [CODE_W-1:0] FUNC_ESTOP      = 8'h40;  // Code 64, emergency stop
  localparam logic [CODE_W-1:0] FUNC_JOG        = 8'h06;  // Code 06, jog_function
  localparam logic [CODE_W-1:0] FUNC_NONE       = 8'hFF;  // No function assigned
  localparam logic [POL_W-1:0]  POL_NO          = 2'h0;   // Normally open
  localparam logic [POL_W-1:0]  POL_NC          = 2'h1;   // Normally closed

  // Trip code shown while the emergency-stop trip is latched (37)
  localparam logic [CODE_W-1:0] ESTOP_TRIP_CODE = 8'h25;
  localparam logic [CODE_W-1:0] NO_TRIP_CODE    = 8'h00;

  // ==========================================================================
  // Timing: copy error indication length
  localparam int unsigned CLK_FREQ_MHZ    = 200;
  localparam int unsigned COPY_ERR_US     = 1000;
  localparam int unsigned COPY_ERR_CYCLES = COPY_ERR_US * CLK_FREQ_MHZ;
  localparam int unsigned COPY_CNT_W      = 20;
  localparam logic [COPY_CNT_W-1:0] COPY_CNT_ZERO = 20'h00000;
  localparam logic [COPY_CNT_W-1:0] COPY_CNT_ONE  = 20'h00001;

  // ==========================================================================
  // Reassignment sequencer states
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_SCAN_RD = 6'h02,
    ST_SCAN_CK = 6'h04,
    ST_SET_T1  = 6'h08,
    ST_SET_T3  = 6'h10,
    ST_CLR_T3  = 6'h20
  } seq_state_type;

  // Factory function per terminal
  function automatic logic [CODE_W-1:0] factory_func(input logic [IDX_W-1:0] idx);
    if (idx == TERM1_IDX) begin
      return FUNC_TRIP_RESET;
    end else if (idx == TERM3_IDX) begin
      return FUNC_JOG;
    end
    return FUNC_NONE;
  endfunction

endpackage
`default_nettype wire

// ===== tb_estop_interlock.sv
// Self-checking bench for the emergency-stop interlock and its field wiring model.
// Assumes the checker binds itself; the copy error length is shortened to 8.
`timescale 1ns/1ps
`default_nettype none
module tb_estop_interlock;
  import estop_pkg::*;
  // ==========================================================================
  // Signals and expected table
  logic       ref_clk_in = 1'b0;
  logic       nrst_in    = 1'b0;
  logic       sw = 1'b0, stop_cmd = 1'b0, open_cmd = 1'b0, press_cmd = 1'b0;
  logic       wr = 1'b0, cp = 1'b0;
  logic [2:0] wt = 3'h0, rt = 3'h0;
  logic [7:0] wf = 8'h00;
  logic [1:0] wp = 2'h0;
  logic       t1, t3, gate, trip, dr, rf, ce, bz, asg;
  logic [7:0] rdf, code;
  logic [1:0] rdp;
  logic [7:0] ef [8];
  logic [1:0] ep [8];
  int         fails = 0;
  int         cmp_count = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  estop_field_model i_estop_field_model (.stop_cmd_in(stop_cmd), .open_cmd_in(open_cmd),
    .press_cmd_in(press_cmd), .trip_reset_input_out(t1), .emergency_stop_input_out(t3));
  estop_interlock #(.COPY_ERR_LEN(8)) i_estop_interlock (.ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in), .estop_enable_switch_in(sw), .trip_reset_input_in(t1),
    .emergency_stop_input_in(t3), .wr_in(wr), .wr_copy_in(cp), .wr_term_in(wt),
    .wr_func_in(wf), .wr_pol_in(wp), .rd_term_in(rt), .rd_func_out(rdf), .rd_pol_out(rdp),
    .gate_enable_out(gate), .estop_trip_out(trip), .trip_code_out(code),
    .device_reset_out(dr), .wr_refused_out(rf), .copy_error_out(ce), .busy_out(bz),
    .estop_assigned_out(asg));

  // ==========================================================================
  // Helpers
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Polarity the table must hold after a write
  function automatic logic [1:0] pol_of(input logic [7:0] f, input logic [1:0] p);
    return (f == FUNC_TRIP_RESET) ? POL_NO : ((f == FUNC_ESTOP) ? POL_NC : p);
  endfunction
  // One write; refusal pulse may land one or two edges late, so watch three
  task automatic put(input logic [2:0] t, input logic [7:0] f, input logic [1:0] p,
                     input logic c, input logic rx);
    logic seen;
    seen = 1'b0;
    {wt, wf, wp, cp, wr} <= {t, f, p, c, 1'b1};
    tick(1);
    wr <= 1'b0;
    repeat (3) begin
      seen = seen | rf;
      tick(1);
    end
    chk({7'h00, seen}, {7'h00, rx});
    if (!rx && !(c && sw && (t == TERM1_IDX || t == TERM3_IDX))) begin
      ef[t] = f;
      ep[t] = pol_of(f, p);
    end
  endtask
  task automatic chk_table();
    for (int i = 0; i < 8; i++) begin
      rt <= 3'(i);
      tick(2);
      chk(rdf, ef[i]);
      chk({6'h00, rdp}, {6'h00, ep[i]});
    end
  endtask
  // Sequencer start lags the switch, so give it two edges first
  task automatic wait_idle();
    int n;
    n = 0;
    tick(2);
    while (bz !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    if (n >= 100) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic apply_on();
    for (int i = 1; i < 8; i++) begin
      if (ef[i] == FUNC_TRIP_RESET) begin
        ef[i] = FUNC_NONE;
      end
    end
    {ef[0], ep[0], ef[2], ep[2]} = {FUNC_TRIP_RESET, POL_NO, FUNC_ESTOP, POL_NC};
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(84));
    for (int i = 0; i < 8; i++) begin
      {ef[i], ep[i]} = {FUNC_NONE, POL_NO};
    end
    {ef[0], ef[2]} = {FUNC_TRIP_RESET, FUNC_JOG};
    repeat (8) @(posedge ref_clk_in);
    tick(1);
    nrst_in <= 1'b1;
    wait_idle();
    chk_table();
    $display("test factory done");
    put(3'h1, FUNC_TRIP_RESET, POL_NC, 1'b0, 1'b0);
    put(TERM3_IDX, FUNC_ESTOP, POL_NC, 1'b0, 1'b1);
    repeat (6) put(3'h3 + 3'($urandom % 5), 8'($urandom), 2'($urandom), 1'b0, 1'b0);
    chk_table();
    $display("test panel writes done");
    sw <= 1'b1;
    apply_on();
    put(3'h5, FUNC_JOG, POL_NO, 1'b0, 1'b1);
    wait_idle();
    chk({7'h00, asg}, 8'h01);
    chk_table();
    put(TERM1_IDX, FUNC_JOG, POL_NC, 1'b0, 1'b1);
    put(TERM3_IDX, FUNC_JOG, POL_NO, 1'b0, 1'b1);
    put(TERM1_IDX, FUNC_JOG, POL_NC, 1'b1, 1'b0);
    chk({7'h00, ce}, 8'h01);
    tick(10);
    chk({7'h00, ce}, 8'h00);
    put(3'h4, 8'($urandom), 2'($urandom), 1'b1, 1'b0);
    chk_table();
    $display("test switch on done");
    stop_cmd <= 1'b1;
    tick(2);
    chk({trip, gate, 6'h00}, 8'h80);
    chk(code, ESTOP_TRIP_CODE);
    stop_cmd <= 1'b0;
    tick(5);
    chk({7'h00, trip}, 8'h01);
    stop_cmd <= 1'b1;
    press_cmd <= 1'b1;
    tick(3);
    chk({7'h00, trip}, 8'h01);
    {stop_cmd, press_cmd} <= 2'b00;
    tick(2);
    press_cmd <= 1'b1;
    tick(1);
    chk({trip, gate, dr, code[4:0]}, 8'h60);
    tick(1);
    chk({7'h00, dr}, 8'h00);
    {open_cmd, press_cmd} <= 2'b10;
    tick(2);
    chk({7'h00, trip}, 8'h01);
    {open_cmd, press_cmd} <= 2'b01;
    tick(2);
    chk({7'h00, trip}, 8'h00);
    press_cmd <= 1'b0;
    $display("test trip done");
    sw <= 1'b0;
    ef[2] = FUNC_NONE;
    wait_idle();
    chk({7'h00, asg}, 8'h00);
    chk_table();
    stop_cmd <= 1'b1;
    tick(3);
    chk({trip, gate, 6'h00}, 8'h40);
    stop_cmd <= 1'b0;
    $display("test switch off done");
    stop_test();
  end
endmodule // tb_estop_interlock
`default_nettype wire

// ===== term_table.sv
// Terminal function and contact polarity table, eight entries.
// Assumes the owner serialises writes; read data appear one clock after the address.
`timescale 1ns/1ps
`default_nettype none
module term_table
  import estop_pkg::*;
(
  input  wire logic   ref_clk_in,
  input  wire logic   nrst_in,
  term_table_if.store tbl
);

  // ==========================================================================
  // Storage
  logic [CODE_W-1:0] func_mem [TERM_COUNT];
  logic [POL_W-1:0]  pol_mem  [TERM_COUNT];
  logic [CODE_W-1:0] next_func_mem [TERM_COUNT];
  logic [POL_W-1:0]  next_pol_mem  [TERM_COUNT];

  // Single write port; untouched entries hold
  always_comb begin
    for (int i = 0; i < TERM_COUNT; i++) begin
      next_func_mem[i] = func_mem[i];
      next_pol_mem[i]  = pol_mem[i];
    end
    if (tbl.we) begin
      next_func_mem[tbl.waddr] = tbl.wfunc;
      next_pol_mem[tbl.waddr]  = tbl.wpol;
    end
  end

  // Factory contents on reset, registered read data
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < TERM_COUNT; i++) begin
        func_mem[i] <= factory_func(IDX_W'(i));
        pol_mem[i]  <= POL_NO;
      end
      tbl.rfunc <= FUNC_NONE;
      tbl.rpol  <= POL_NO;
    end else begin
      for (int i = 0; i < TERM_COUNT; i++) begin
        func_mem[i] <= next_func_mem[i];
        pol_mem[i]  <= next_pol_mem[i];
      end
      tbl.rfunc <= func_mem[tbl.raddr];
      tbl.rpol  <= pol_mem[tbl.raddr];
    end
  end

endmodule // term_table
`default_nettype wire

// ===== term_table_if.sv
// Port bundle between the interlock and its terminal function table.
// Assumes one write and one registered read per clock.
`timescale 1ns/1ps
`default_nettype none
interface term_table_if;
  import estop_pkg::*;

  // ==========================================================================
  // Write and read channels
  logic              we;
  logic [IDX_W-1:0]  waddr;
  logic [CODE_W-1:0] wfunc;
  logic [POL_W-1:0]  wpol;
  logic [IDX_W-1:0]  raddr;
  logic [CODE_W-1:0] rfunc;
  logic [POL_W-1:0]  rpol;

  modport owner (output we, waddr, wfunc, wpol, raddr, input rfunc, rpol);
  modport store (input we, waddr, wfunc, wpol, raddr, output rfunc, rpol);
endinterface
`default_nettype wire
